/* File: hw/pds_pkg.sv */
// constants and types of the power-down and start-up sequencer
//------------------------------------------------------------
// Functional notes
//------------------------------------------------------------
// Functional notes
// - while power_down_n is low everything is off, serial access too, except spi_mode and rom_page, which keep their latched values.
// - a rising power_down_n starts power-on reset, then start-up, then run.
// - reset holds until core supplies are good and power_down_n is high.
// - at start-up interface_select_strap high picks SPI, low picks I2C.
// - at start-up the two 3-level rom page straps pick the config page.
// - oscillators one and two calibrate on a valid reference oscillator.
// - a soft reset re-runs calibration and the start-up of PLLs one and two; the third loop stays enabled.
// - analog_pll_three needs no calibration and locks once reference is ok.
// - digital_pll_three reference is never validated before the oscillator.
// - host programs, sets output sync hold, soft resets, then clears it.
// - register access works in every state after power-on reset.
package pds_pkg;

  localparam int PDS_ADDR_W = 8;
  localparam logic [7:0] PDS_CTRL_OFF = 8'h00;
  localparam logic [7:0] PDS_STAT_OFF = 8'h04;

  // control register fields
  localparam int PDS_CTRL_SRST_BIT = 0;
  localparam int PDS_CTRL_HOLD_BIT = 1;
  localparam logic PDS_HOLD_RST = 1'b0;

  // status register fields
  localparam int PDS_STAT_ST_LSB = 0;
  localparam int PDS_STAT_SPI_BIT = 4;
  localparam int PDS_STAT_PAGE_LSB = 8;
  localparam int PDS_STAT_FAIL_BIT = 12;
  localparam int PDS_STAT_LK1_BIT = 16;
  localparam int PDS_STAT_LK2_BIT = 17;
  localparam int PDS_STAT_LK3_BIT = 18;
  localparam int PDS_STAT_A3_BIT = 19;
  localparam int PDS_STAT_D3_BIT = 20;

  // three-level strap codes from the pin level detector
  localparam logic [1:0] PDS_LVL_LOW = 2'h0;
  localparam logic [1:0] PDS_LVL_MID = 2'h1;
  localparam logic [3:0] PDS_PAGE_RADIX = 4'h3;

  // synchronised pins: pd, supply, ref, ifsel, page low(2), page high(2)
  localparam int PDS_SYNC_W = 8;

  // timing
  localparam int PDS_CLK_PERIOD_NS = 10;
  localparam int PDS_PD_MIN_NS = 200;
  localparam int PDS_PD_MIN_CYC =
    (PDS_PD_MIN_NS + PDS_CLK_PERIOD_NS - 1) / PDS_CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    pds_st_off,
    pds_st_por,
    pds_st_strap,
    pds_st_wref,
    pds_st_cal,
    pds_st_lock,
    pds_st_run,
    pds_st_fail
  } pds_state_e;

endpackage

/* File: hw/pds_sync2.sv */
// two flip-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module pds_sync2 #(
  parameter int W = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } pds_sync_s;

  pds_sync_s r_r;
  pds_sync_s r_nxt;

  always_comb begin
    r_nxt.s1 = d;
    r_nxt.s2 = r_r.s1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign q = r_r.s2;

endmodule

/* File: hw/pds_seq.sv */
// power-down, power-on reset and PLL start-up sequencer with APB registers
//
// Chosen here: the register offsets and register access over APB.
`timescale 1ns/1ps
module pds_seq (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pds_pkg::PDS_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic power_down_n,
  input wire logic supply_ok,
  input wire logic reference_oscillator_valid,
  input wire logic interface_select_strap,
  input wire logic [1:0] rom_page_strap_low,
  input wire logic [1:0] rom_page_strap_high,
  input wire logic oscillator_one_cal_done,
  input wire logic oscillator_two_cal_done,
  input wire logic analog_pll_one_lock,
  input wire logic analog_pll_two_lock,
  input wire logic analog_pll_three_lock,
  output logic device_enable,
  output logic cal_start,
  output logic pll_enable,
  output logic analog_pll_three_enable,
  output logic digital_pll_three_ref_enable,
  output logic spi_mode,
  output logic [3:0] rom_page,
  output logic output_sync_hold
);
  import pds_pkg::*;

  //------------------------------------------------------------
  // state
  //------------------------------------------------------------
  typedef struct packed {
    pds_state_e st;
    logic hold;
    logic spi;
    logic [3:0] page;
    logic fail;
    logic a3_en;
    logic d3_en;
    logic [31:0] rdata;
  } pds_regs_s;

  pds_regs_s r_r;
  pds_regs_s r_nxt;

  logic [PDS_SYNC_W-1:0] pins_s;
  logic pd_s;
  logic sup_s;
  logic ref_s;
  logic ifsel_s;
  logic [1:0] plo_s;
  logic [1:0] phi_s;
  logic on;
  logic setup;
  logic access;
  logic hit_ctrl;
  logic hit_stat;
  logic wr_ctrl;
  logic srst;

  //------------------------------------------------------------
  // pin synchronisers
  //------------------------------------------------------------
  pds_sync2 #(
    .W(PDS_SYNC_W)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({power_down_n, supply_ok, reference_oscillator_valid,
        interface_select_strap, rom_page_strap_low,
        rom_page_strap_high}),
    .q(pins_s)
  );

  assign pd_s = pins_s[7];
  assign sup_s = pins_s[6];
  assign ref_s = pins_s[5];
  assign ifsel_s = pins_s[4];
  assign plo_s = pins_s[3:2];
  assign phi_s = pins_s[1:0];

  function automatic logic [3:0] lvl(input logic [1:0] c);
    logic [3:0] v;
    v = 4'h2;
    if (c == PDS_LVL_LOW) begin
      v = 4'h0;
    end else if (c == PDS_LVL_MID) begin
      v = 4'h1;
    end
    return v;
  endfunction

  //------------------------------------------------------------
  // apb decode
  //------------------------------------------------------------
  // serial interface is dead while powered down or held in reset
  assign on = (r_r.st != pds_st_off) && (r_r.st != pds_st_por);
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign hit_ctrl = (paddr == PDS_CTRL_OFF);
  assign hit_stat = (paddr == PDS_STAT_OFF);
  assign wr_ctrl = access && pwrite && on && hit_ctrl;
  assign srst = wr_ctrl && pwdata[PDS_CTRL_SRST_BIT];

  assign pready = access;
  assign pslverr = access && (!on || !(hit_ctrl || hit_stat));
  assign prdata = r_r.rdata;

  //------------------------------------------------------------
  // next state
  //------------------------------------------------------------
  always_comb begin
    logic [31:0] stat;
    stat = '0;
    r_nxt = r_r;

    stat[PDS_STAT_ST_LSB +: 3] = r_r.st;
    stat[PDS_STAT_SPI_BIT] = r_r.spi;
    stat[PDS_STAT_PAGE_LSB +: 4] = r_r.page;
    stat[PDS_STAT_FAIL_BIT] = r_r.fail;
    stat[PDS_STAT_LK1_BIT] = analog_pll_one_lock;
    stat[PDS_STAT_LK2_BIT] = analog_pll_two_lock;
    stat[PDS_STAT_LK3_BIT] = analog_pll_three_lock;
    stat[PDS_STAT_A3_BIT] = r_r.a3_en;
    stat[PDS_STAT_D3_BIT] = r_r.d3_en;

    // read data is captured in the setup cycle, ready in the access cycle
    if (setup) begin
      r_nxt.rdata = '0;
      if (on && hit_stat) begin
        r_nxt.rdata = stat;
      end else if (on && hit_ctrl) begin
        r_nxt.rdata[PDS_CTRL_HOLD_BIT] = r_r.hold;
      end
    end

    if (wr_ctrl) begin
      r_nxt.hold = pwdata[PDS_CTRL_HOLD_BIT];
    end

    unique case (r_r.st)
      pds_st_off: begin
        if (pd_s) begin
          r_nxt.st = pds_st_por;
        end
      end
      pds_st_por: begin
        if (sup_s) begin
          r_nxt.st = pds_st_strap;
        end
      end
      pds_st_strap: begin
        r_nxt.spi = ifsel_s;
        r_nxt.page = lvl(plo_s) + PDS_PAGE_RADIX * lvl(phi_s);
        r_nxt.st = pds_st_wref;
      end
      pds_st_wref: begin
        if (ref_s) begin
          r_nxt.st = pds_st_cal;
        end
      end
      pds_st_cal: begin
        if (!ref_s) begin
          r_nxt.st = pds_st_fail;
          r_nxt.fail = 1'b1;
        end else if (oscillator_one_cal_done &&
                     oscillator_two_cal_done) begin
          r_nxt.st = pds_st_lock;
        end
      end
      pds_st_lock: begin
        if (analog_pll_one_lock && analog_pll_two_lock) begin
          r_nxt.st = pds_st_run;
        end
      end
      pds_st_run: begin
        r_nxt.st = pds_st_run;
      end
      pds_st_fail: begin
        r_nxt.st = pds_st_fail;
      end
    endcase

    // soft reset restarts calibration but keeps the latched straps
    if (srst) begin
      r_nxt.st = pds_st_wref;
      r_nxt.fail = 1'b0;
    end

    // third loop needs a valid reference while on and outside the strap state, whenever it comes
    r_nxt.a3_en = on && (r_r.st != pds_st_strap) && ref_s;
    r_nxt.d3_en = r_r.a3_en && ref_s;

    if (!pd_s) begin
      r_nxt.st = pds_st_off;
      r_nxt.rdata = '0;
      r_nxt.hold = PDS_HOLD_RST;
      r_nxt.fail = 1'b0;
      r_nxt.a3_en = 1'b0;
      r_nxt.d3_en = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_r <= '{st: pds_st_off, hold: PDS_HOLD_RST, default: '0};
    end else begin
      r_r <= r_nxt;
    end
  end

  //------------------------------------------------------------
  // outputs
  //------------------------------------------------------------
  assign device_enable = on;
  assign cal_start = (r_r.st == pds_st_cal);
  assign pll_enable = (r_r.st == pds_st_lock) || (r_r.st == pds_st_run);
  assign analog_pll_three_enable = r_r.a3_en;
  assign digital_pll_three_ref_enable = r_r.d3_en;
  assign spi_mode = r_r.spi;
  assign rom_page = r_r.page;
  assign output_sync_hold = r_r.hold;

  //------------------------------------------------------------
  // assertions
  //------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  pd_off_a: assert property (!pd_s |=> r_r.st == pds_st_off)
    else $error("power-down low did not force the off state");

  por_start_a: assert property (
    r_r.st == pds_st_off && pd_s |=> r_r.st == pds_st_por)
    else $error("power-down release did not start power-on reset");

  por_hold_a: assert property (
    r_r.st == pds_st_por && !sup_s && pd_s
    |=> r_r.st == pds_st_por)
    else $error("left reset before supplies were good");

  iface_sel_a: assert property (
    r_r.st == pds_st_strap && pd_s
    |=> spi_mode == $past(ifsel_s))
    else $error("interface strap not latched");

  page_sel_a: assert property (
    r_r.st == pds_st_strap && plo_s == PDS_LVL_MID && pd_s
    && phi_s == PDS_LVL_LOW |=> rom_page == 4'h1)
    else $error("rom page strap decode wrong");

  cal_ref_a: assert property (
    r_r.st == pds_st_cal && !ref_s && pd_s && !srst
    |=> r_r.st == pds_st_fail && r_r.fail)
    else $error("calibration went on without a reference");

  cal_entry_a: assert property (
    r_r.st == pds_st_wref && pd_s && !srst
    |=> (r_r.st == pds_st_cal) == $past(ref_s))
    else $error("calibration entry does not follow the reference");

  srst_rerun_a: assert property (
    srst && pd_s |=> r_r.st == pds_st_wref ##1 !cal_start || ref_s)
    else $error("soft reset did not restart calibration");

  pll3_lock_a: assert property (
    on && r_r.st != pds_st_strap && ref_s && pd_s
    |=> analog_pll_three_enable)
    else $error("third loop not enabled on valid reference");

  pll3_order_a: assert property (
    digital_pll_three_ref_enable |-> analog_pll_three_enable
    && $past(ref_s, 2))
    else $error("third loop reference validated too early");

  sync_hold_a: assert property (
    wr_ctrl && pd_s
    |=> output_sync_hold == $past(pwdata[PDS_CTRL_HOLD_BIT]))
    else $error("sync hold bit not written");

  apb_block_a: assert property (
    access && !on |-> pslverr && prdata == 32'h0)
    else $error("register access accepted while off");

  strap_keep_a: assert property (
    r_r.st != pds_st_strap && $past(r_r.st) != pds_st_strap
    |-> $stable(spi_mode) && $stable(rom_page))
    else $error("straps changed outside start-up");

  run_c: cover property (r_r.st == pds_st_lock ##1 r_r.st == pds_st_run);
  fail_c: cover property (r_r.st == pds_st_fail);
  srst_c: cover property (r_r.st == pds_st_run && srst);
  pd_c: cover property (r_r.st == pds_st_run ##1 !pd_s);
  late_ref_c: cover property (
    r_r.st == pds_st_wref && !ref_s ##1 r_r.st == pds_st_wref && ref_s);

endmodule

/* File: verif/pds_partner.sv */
// partner model: oscillator calibration and pll lock responses
`timescale 1ns/1ps
module pds_partner (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow,
  input wire logic cal_start,
  input wire logic pll_enable,
  input wire logic analog_pll_three_enable,
  output logic oscillator_one_cal_done,
  output logic oscillator_two_cal_done,
  output logic analog_pll_one_lock,
  output logic analog_pll_two_lock,
  output logic analog_pll_three_lock
);
  logic [5:0] cal_cnt;
  logic [5:0] lock_cnt;
  logic [5:0] dly;
  assign dly = slow ? 6'h14 : 6'h02;
  // counters restart whenever their enable drops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_cnt <= 6'h00;
      lock_cnt <= 6'h00;
      analog_pll_three_lock <= 1'b0;
    end else begin
      cal_cnt <= cal_start ? cal_cnt + 6'(cal_cnt <= dly) : 6'h00;
      lock_cnt <= pll_enable ? lock_cnt + 6'(lock_cnt <= dly) : 6'h00;
      analog_pll_three_lock <= analog_pll_three_enable;
    end
  end
  assign oscillator_one_cal_done = cal_start && cal_cnt >= dly;
  assign oscillator_two_cal_done = cal_start && cal_cnt > dly;
  assign analog_pll_one_lock = pll_enable && lock_cnt >= dly;
  assign analog_pll_two_lock = pll_enable && lock_cnt > dly;
endmodule

/* File: verif/tb_top.sv */
// testbench of the power-down and start-up sequencer
`timescale 1ns/1ps
module tb_top;
  import pds_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic power_down_n = 0, supply_ok = 0, interface_select_strap = 0;
  logic reference_oscillator_valid = 0, slow = 0;
  logic [1:0] rom_page_strap_low = 0, rom_page_strap_high = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, device_enable, cal_start, pll_enable;
  logic analog_pll_three_enable, digital_pll_three_ref_enable;
  logic spi_mode, output_sync_hold;
  logic [3:0] rom_page;
  logic oscillator_one_cal_done, oscillator_two_cal_done;
  logic analog_pll_one_lock, analog_pll_two_lock, analog_pll_three_lock;
  int n_errors = 0, checks_done = 0;

  always #5 pclk = ~pclk;

  pds_seq pds_seq_inst (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .power_down_n,
    .supply_ok, .reference_oscillator_valid, .interface_select_strap,
    .rom_page_strap_low, .rom_page_strap_high, .oscillator_one_cal_done,
    .oscillator_two_cal_done, .analog_pll_one_lock, .analog_pll_two_lock,
    .analog_pll_three_lock, .device_enable, .cal_start, .pll_enable,
    .analog_pll_three_enable, .digital_pll_three_ref_enable, .spi_mode,
    .rom_page, .output_sync_hold);

  pds_partner pds_partner_inst (.pclk, .presetn, .slow, .cal_start,
    .pll_enable, .analog_pll_three_enable, .oscillator_one_cal_done,
    .oscillator_two_cal_done, .analog_pll_one_lock, .analog_pll_two_lock,
    .analog_pll_three_lock);

  //------------------------------------------------------------
  // tasks
  //------------------------------------------------------------
  task automatic tally_and_finish();
    $display("errors=%0d checks=%0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // one apb transfer; holds the request until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    // pready follows the access cycle, so this wait ends at the first edge
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task automatic wait_st(input logic [2:0] st);
    int n;
    n = 0;
    do apb(0, PDS_STAT_OFF, 0); while (rd[2:0] !== st && ++n < 100);
    chk(rd[2:0], st);
  endtask

  //------------------------------------------------------------
  // tests
  //------------------------------------------------------------
  initial begin
    #300000;
    n_errors++;
    tally_and_finish();
  end

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1;
    apb(0, PDS_STAT_OFF, 0);
    chk(err, 1);
    chk(rd, 0);
    chk(device_enable, 0);
    // strap low code 3 counts as 2: page 2 + 3*1
    interface_select_strap <= 1;
    rom_page_strap_low <= 2'h3;
    rom_page_strap_high <= 2'h1;
    supply_ok <= 1;
    reference_oscillator_valid <= 1;
    repeat (4) @(posedge pclk);
    power_down_n <= 1;
    wait_st(6);
    chk(rd[PDS_STAT_D3_BIT:PDS_STAT_LK1_BIT], 5'h1f);
    chk(pll_enable, 1);
    chk(cal_start, 0);
    chk(spi_mode, 1);
    chk(rom_page, 5);
    chk(analog_pll_three_enable, 1);
    chk(digital_pll_three_ref_enable, 1);
    // soft reset under output sync hold, straps changed meanwhile
    slow <= 1;
    interface_select_strap <= 0;
    rom_page_strap_low <= 2'h0;
    rom_page_strap_high <= 2'h2;
    apb(1, PDS_CTRL_OFF, 32'h2);
    // the register output shows the write one edge later
    @(posedge pclk);
    chk(output_sync_hold, 1);
    apb(1, PDS_CTRL_OFF, 32'h3);
    wait_st(4);
    chk(cal_start, 1);
    wait_st(6);
    apb(0, PDS_CTRL_OFF, 0);
    chk(rd, 32'h2);
    apb(1, PDS_CTRL_OFF, 32'h0);
    @(posedge pclk);
    chk(output_sync_hold, 0);
    chk(spi_mode, 1);
    chk(rom_page, 5);
    // reference lost during calibration, then soft reset retries
    apb(1, PDS_CTRL_OFF, 32'h1);
    wait_st(4);
    reference_oscillator_valid <= 0;
    wait_st(7);
    chk(rd[PDS_STAT_FAIL_BIT], 1);
    chk(analog_pll_three_enable, 0);
    reference_oscillator_valid <= 1;
    apb(1, PDS_CTRL_OFF, 32'h1);
    wait_st(6);
    apb(0, 8'h08, 0);
    chk(err, 1);
    // hard reset pulse longer than 200 ns, reference still absent
    apb(1, PDS_CTRL_OFF, 32'h2);
    slow <= 0;
    power_down_n <= 0;
    reference_oscillator_valid <= 0;
    repeat (PDS_PD_MIN_CYC + 5) @(posedge pclk);
    chk(device_enable, 0);
    chk(output_sync_hold, 0);
    rom_page_strap_low <= 2'h1;
    power_down_n <= 1;
    wait_st(3);
    chk(analog_pll_three_enable, 0);
    chk(digital_pll_three_ref_enable, 0);
    reference_oscillator_valid <= 1;
    wait_st(6);
    chk(spi_mode, 0);
    chk(rom_page, 7);
    // supply not good keeps the device in reset
    power_down_n <= 0;
    supply_ok <= 0;
    repeat (5) @(posedge pclk);
    power_down_n <= 1;
    repeat (20) @(posedge pclk);
    chk(device_enable, 0);
    apb(0, PDS_STAT_OFF, 0);
    chk(err, 1);
    supply_ok <= 1;
    wait_st(6);
    tally_and_finish();
  end
endmodule
